// [hw/sram_port_regs.svh]
// register offsets, field positions and control reset value of the sram port
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

// ==========================================================
// register offsets (byte addresses)
`define OFS_CTRL         4'h0
`define OFS_STATUS       4'h4
`define OFS_RD_COUNT     4'h8
`define OFS_WR_COUNT     4'hc

// ==========================================================
// control register fields
`define CTRL_FLOWTHRU_N  0
`define CTRL_LINEAR_N    1
`define CTRL_DESEL_DEPTH 2
`define CTRL_SLEEP       3
`define CTRL_DRIVE_STR   4
`define CTRL_WIDTH       5
`define CTRL_RESET       5'h17

// ==========================================================
// status register fields
`define STAT_BURST       0
`define STAT_ADDR_LO     1
`define STAT_SLEEP       3
`define STAT_PIPE        4
`define STAT_DRIVE       5

// ==========================================================
// bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// [hw/sram_port_pkg.sv]
// types shared by the burst sram port modules
`default_nettype none

package sram_port_pkg;
  typedef enum logic [3:0] {
    OP_NONE  = 4'b0001,
    OP_DESEL = 4'b0010,
    OP_READ  = 4'b0100,
    OP_WRITE = 4'b1000
  } op_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BURST = 3'b010,
    ST_SLEEP = 3'b100
  } port_state_e;

  typedef logic [1:0] burst_addr_t;
endpackage : sram_port_pkg

`default_nettype wire

// [hw/burst_if.sv]
// link between the port control and the burst address counter
`timescale 1ns/1ps
`default_nettype none

interface burst_if;
  logic                      load;
  logic                      advance;
  logic                      interleave;
  sram_port_pkg::burst_addr_t preset;
  sram_port_pkg::burst_addr_t cur_addr;
  sram_port_pkg::burst_addr_t next_addr;

  modport ctrl (output load, advance, interleave, preset,
                input  cur_addr, next_addr);
  modport ctr  (input  load, advance, interleave, preset,
                output cur_addr, next_addr);
endinterface : burst_if

`default_nettype wire

// [hw/burst_counter.sv]
// two-bit burst address counter, linear or interleaved order
`timescale 1ns/1ps
`default_nettype none

module burst_counter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control side
  burst_if.ctr     bus
);
  import sram_port_pkg::*;

  burst_addr_t start_reg;
  burst_addr_t count_reg;
  burst_addr_t count_inc;

  function automatic burst_addr_t seq(input burst_addr_t s,
                                      input burst_addr_t c,
                                      input logic il);
    seq = il ? (s ^ c) : burst_addr_t'(s + c);
  endfunction : seq

  // two-bit count wraps to the preset after four addresses
  assign count_inc = burst_addr_t'(count_reg + 2'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_reg <= 2'h0;
    end else if (bus.load) begin
      start_reg <= bus.preset;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 2'h0;
    end else if (bus.load) begin
      count_reg <= 2'h0;
    end else if (bus.advance) begin
      count_reg <= count_inc;
    end
  end

  assign bus.cur_addr  = seq(start_reg, count_reg, bus.interleave);
  assign bus.next_addr = seq(start_reg, count_inc, bus.interleave);
endmodule : burst_counter

`default_nettype wire

// [hw/lane_store.sv]
// storage array with per-lane write enables
`timescale 1ns/1ps
`default_nettype none

module lane_store #(
  parameter int ADDR_W = 19,
  parameter int LANES  = 8,
  parameter int LANE_W = 9
) (
  // clock
  input  wire logic                      aclk,
  // access
  input  wire logic                      we,
  input  wire logic [LANES-1:0]          lane_we,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [LANES*LANE_W-1:0]   wdata,
  output logic      [LANES*LANE_W-1:0]   rdata
);
  logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge aclk) begin
    if (we) begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_we[i]) begin
          mem[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  assign rdata = mem[addr];
endmodule : lane_store

`default_nettype wire

// [hw/sync_burst_sram_port.sv]
// synchronous burst sram port: decode, burst, data path, register slave
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_regs.svh"

module sync_burst_sram_port #(
  parameter int ADDR_W = 19,
  parameter int LANES  = 8,
  parameter int LANE_W = 9
) (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // register bus write address
  input  wire logic [31:0]             awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  // register bus write data
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  // register bus write response
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // register bus read address
  input  wire logic [31:0]             araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  // register bus read data
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // memory address and burst control
  input  wire logic [ADDR_W-1:0]       ext_addr,
  input  wire logic                    proc_addr_strobe_n,
  input  wire logic                    ctrl_addr_strobe_n,
  input  wire logic                    burst_advance_n,
  // chip selects
  input  wire logic                    select_first_n,
  input  wire logic                    select_second_hi,
  input  wire logic                    select_third_n,
  // write controls
  input  wire logic                    all_bytes_write_n,
  input  wire logic                    byte_write_qualifier_n,
  input  wire logic [LANES-1:0]        lane_write_sel_n,
  // data pins
  input  wire logic                    out_enable_n,
  input  wire logic [LANES*LANE_W-1:0] dq_in,
  output logic      [LANES*LANE_W-1:0] dq_out,
  output logic      [LANES-1:0]        dq_oe,
  // output driver strength
  output logic                         drive_strength_sel
);
  import sram_port_pkg::*;

  // ==========================================================
  // declarations
  localparam int DW = LANES * LANE_W;

  logic [`CTRL_WIDTH-1:0] ctrl_reg;
  logic [31:0]            rd_count_reg;
  logic [31:0]            wr_count_reg;

  logic                   aw_held_reg;
  logic [3:0]             aw_addr_reg;
  logic                   aw_bad_reg;
  logic                   w_held_reg;
  logic [31:0]            w_data_reg;
  logic [3:0]             w_strb_reg;
  logic                   awready_reg;
  logic                   wready_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   arready_reg;
  logic                   rvalid_reg;
  logic [31:0]            rdata_reg;
  logic [1:0]             rresp_reg;

  logic [2:0]             oe_sync_reg;
  logic                   oe_n_reg;

  port_state_e            state_reg;
  port_state_e            state_next;
  op_e                    op;
  logic [ADDR_W-3:0]      base_reg;
  logic [ADDR_W-1:0]      addr_now;
  logic [LANES-1:0]       lane_we;
  logic [DW-1:0]          rd_word;

  logic                   stage_read_reg;
  logic [DW-1:0]          stage_data_reg;
  logic                   desel_dly_reg;
  logic                   drive_reg;
  logic                   drive_next;
  logic [DW-1:0]          dq_out_reg;
  logic [LANES-1:0]       dq_oe_reg;

  logic pipe_mode;
  logic dual_desel;
  logic sleep_mode;
  logic selected;
  logic proc_start;
  logic start;
  logic is_write;
  logic read_on;
  logic off_now;

  // ==========================================================
  // mode bits
  assign pipe_mode  = ctrl_reg[`CTRL_FLOWTHRU_N];
  assign dual_desel = ~ctrl_reg[`CTRL_DESEL_DEPTH];
  assign sleep_mode = ctrl_reg[`CTRL_SLEEP];

  // ==========================================================
  // cycle decode
  assign selected   = ~select_first_n & select_second_hi
                    & ~select_third_n;
  // processor strobe is ignored while the first enable is high
  assign proc_start = ~proc_addr_strobe_n & ~select_first_n;
  assign start      = proc_start | ~ctrl_addr_strobe_n;
  assign is_write   = ~all_bytes_write_n
                    | ~byte_write_qualifier_n;

  always_comb begin
    if (!all_bytes_write_n) begin
      lane_we = {LANES{1'b1}};
    end else if (!byte_write_qualifier_n) begin
      lane_we = ~lane_write_sel_n;
    end else begin
      lane_we = {LANES{1'b0}};
    end
  end

  always_comb begin
    op = OP_NONE;
    if (sleep_mode) begin
      op = OP_NONE;
    end else if (start) begin
      if (!selected) begin
        op = OP_DESEL;
      end else if (proc_start) begin
        op = OP_READ;
      end else begin
        op = is_write ? OP_WRITE : OP_READ;
      end
    end else if (state_reg == ST_BURST) begin
      op = is_write ? OP_WRITE : OP_READ;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE, ST_BURST: begin
        if (sleep_mode) begin
          state_next = ST_SLEEP;
        end else if (start) begin
          state_next = selected ? ST_BURST : ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (!sleep_mode) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // burst address
  burst_if bif ();

  assign bif.load       = start & selected & ~sleep_mode;
  assign bif.advance    = ~sleep_mode & ~start & ~burst_advance_n
                        & (state_reg == ST_BURST);
  assign bif.interleave = ctrl_reg[`CTRL_LINEAR_N];
  assign bif.preset     = ext_addr[1:0];

  burst_counter u_burst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (bif)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_reg <= '0;
    end else if (bif.load) begin
      base_reg <= ext_addr[ADDR_W-1:2];
    end
  end

  // a new address is used directly; a continuing burst swaps in the count
  always_comb begin
    if (start) begin
      addr_now = ext_addr;
    end else if (bif.advance) begin
      addr_now = {base_reg, bif.next_addr};
    end else begin
      addr_now = {base_reg, bif.cur_addr};
    end
  end

  // ==========================================================
  // storage
  lane_store #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_store (
    .aclk    (aclk),
    .we      (op == OP_WRITE),
    .lane_we (lane_we),
    .addr    (addr_now),
    .wdata   (dq_in),
    .rdata   (rd_word)
  );

  // ==========================================================
  // output enable pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_sync_reg <= 3'h7;
    end else begin
      oe_sync_reg <= {oe_sync_reg[1:0], out_enable_n};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_n_reg <= 1'b1;
    end else if (oe_sync_reg[1] == oe_sync_reg[2]) begin
      oe_n_reg <= oe_sync_reg[2];
    end
  end

  // ==========================================================
  // read data path
  assign read_on = pipe_mode ? stage_read_reg : (op == OP_READ);
  assign off_now = (op == OP_WRITE) | sleep_mode
                 | ((op == OP_DESEL) & ~dual_desel)
                 | (desel_dly_reg & dual_desel);
  assign drive_next = off_now ? 1'b0 : (read_on | drive_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_read_reg <= 1'b0;
      desel_dly_reg  <= 1'b0;
    end else begin
      stage_read_reg <= (op == OP_READ);
      desel_dly_reg  <= (op == OP_DESEL);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_data_reg <= '0;
    end else if (op == OP_READ) begin
      stage_data_reg <= rd_word;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_out_reg <= '0;
    end else if (pipe_mode && stage_read_reg) begin
      dq_out_reg <= stage_data_reg;
    end else if (!pipe_mode && op == OP_READ) begin
      dq_out_reg <= rd_word;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_reg <= 1'b0;
      dq_oe_reg <= '0;
    end else begin
      drive_reg <= drive_next;
      dq_oe_reg <= {LANES{drive_next & ~oe_n_reg}};
    end
  end

  assign dq_out             = dq_out_reg;
  assign dq_oe              = dq_oe_reg;
  assign drive_strength_sel = ctrl_reg[`CTRL_DRIVE_STR];

  // ==========================================================
  // cycle counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_count_reg <= 32'h0;
      wr_count_reg <= 32'h0;
    end else begin
      if (op == OP_READ) begin
        rd_count_reg <= rd_count_reg + 32'h1;
      end
      if (op == OP_WRITE) begin
        wr_count_reg <= wr_count_reg + 32'h1;
      end
    end
  end

  // ==========================================================
  // register bus write side
  logic        aw_take;
  logic        w_take;
  logic        aw_have;
  logic        w_have;
  logic        do_write;
  logic [3:0]  wr_ofs;
  logic        wr_bad;
  logic [31:0] wr_word;
  logic [3:0]  wr_strb;
  logic        aw_held_next;
  logic        w_held_next;
  logic        bvalid_next;

  assign aw_take  = awvalid & awready_reg;
  assign w_take   = wvalid & wready_reg;
  assign aw_have  = aw_held_reg | aw_take;
  assign w_have   = w_held_reg | w_take;
  assign do_write = aw_have & w_have & ~bvalid_reg;
  assign wr_ofs   = aw_held_reg ? aw_addr_reg : (awaddr[3:0] & 4'hc);
  assign wr_bad   = aw_held_reg ? aw_bad_reg : (awaddr[31:4] != 28'h0);
  assign wr_word  = w_held_reg ? w_data_reg : wdata;
  assign wr_strb  = w_held_reg ? w_strb_reg : wstrb;

  assign aw_held_next = do_write ? 1'b0 : aw_have;
  assign w_held_next  = do_write ? 1'b0 : w_have;
  assign bvalid_next  = do_write | (bvalid_reg & ~bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      awready_reg <= ~aw_held_next & ~bvalid_next;
      wready_reg  <= ~w_held_next & ~bvalid_next;
      bvalid_reg  <= bvalid_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= 4'h0;
      aw_bad_reg  <= 1'b0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= awaddr[3:0] & 4'hc;
        aw_bad_reg  <= (awaddr[31:4] != 28'h0);
      end
      if (w_take) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
    end
  end

  // only the control word is writable; the rest of the map is read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg  <= `CTRL_RESET;
      bresp_reg <= `RESP_OKAY;
    end else if (do_write) begin
      if (!wr_bad && wr_ofs == `OFS_CTRL) begin
        bresp_reg <= `RESP_OKAY;
        if (wr_strb[0]) begin
          ctrl_reg <= wr_word[`CTRL_WIDTH-1:0];
        end
      end else if (!wr_bad && wr_ofs != `OFS_CTRL) begin
        bresp_reg <= `RESP_OKAY;
      end else begin
        bresp_reg <= `RESP_SLVERR;
      end
    end
  end

  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;

  // ==========================================================
  // register bus read side
  logic        ar_take;
  logic        rvalid_next;
  logic [31:0] status_word;

  assign ar_take     = arvalid & arready_reg;
  assign rvalid_next = ar_take | (rvalid_reg & ~rready);

  always_comb begin
    status_word = 32'h0;
    status_word[`STAT_BURST]          = (state_reg == ST_BURST);
    status_word[`STAT_ADDR_LO +: 2]   = bif.cur_addr;
    status_word[`STAT_SLEEP]          = (state_reg == ST_SLEEP);
    status_word[`STAT_PIPE]           = pipe_mode;
    status_word[`STAT_DRIVE]          = drive_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b0;
    end else begin
      rvalid_reg  <= rvalid_next;
      arready_reg <= ~rvalid_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_reg <= 32'h0;
      rresp_reg <= `RESP_OKAY;
    end else if (ar_take) begin
      rresp_reg <= `RESP_OKAY;
      if (araddr[31:4] != 28'h0) begin
        rdata_reg <= 32'h0;
        rresp_reg <= `RESP_SLVERR;
      end else begin
        unique case (araddr[3:0] & 4'hc)
          `OFS_CTRL:     rdata_reg <= {27'h0, ctrl_reg};
          `OFS_STATUS:   rdata_reg <= status_word;
          `OFS_RD_COUNT: rdata_reg <= rd_count_reg;
          `OFS_WR_COUNT: rdata_reg <= wr_count_reg;
          default:       rdata_reg <= 32'h0;
        endcase
      end
    end
  end

  assign arready = arready_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;
endmodule : sync_burst_sram_port

`default_nettype wire

// [testbench/sync_burst_sram_port_props.sv]
// assertions on the memory pins of the burst sram port
`timescale 1ns/1ps
`default_nettype none

module sram_port_props #(
  parameter int LANES  = 8,
  parameter int LANE_W = 9
) (
  // clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // access controls
  input wire logic                    proc_addr_strobe_n,
  input wire logic                    ctrl_addr_strobe_n,
  input wire logic                    select_first_n,
  input wire logic                    select_second_hi,
  input wire logic                    select_third_n,
  input wire logic                    all_bytes_write_n,
  input wire logic                    byte_write_qualifier_n,
  input wire logic                    out_enable_n,
  // data pins
  input wire logic [LANES*LANE_W-1:0] dq_out,
  input wire logic [LANES-1:0]        dq_oe,
  input wire logic                    drive_strength_sel
);
  wire stb = !ctrl_addr_strobe_n;
  wire sel = !select_first_n && select_second_hi && !select_third_n;
  wire nos = ctrl_addr_strobe_n && proc_addr_strobe_n;
  wire wr = stb && sel && !(all_bytes_write_n && byte_write_qualifier_n);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_glob_wr_hiz:
    assert property (stb && sel && !all_bytes_write_n |=> dq_oe == '0)
    else $error("drive on after global write");
  a_byte_wr_hiz:
    assert property (stb && sel && all_bytes_write_n
      && !byte_write_qualifier_n |=> dq_oe == '0)
    else $error("drive on after byte write");
  a_wr_hold:
    assert property (wr ##1 wr |=> $stable(dq_out))
    else $error("data out moved during writes");
  a_lanes_equal:
    assert property (dq_oe == '0 || dq_oe == '1)
    else $error("lanes drive unequally");
  a_oe_gate:
    assert property (out_enable_n [*6] |-> dq_oe == '0)
    else $error("drive on with output enable high");
  a_desel_off:
    assert property (stb && !sel ##1 nos |-> ##1 dq_oe == '0)
    else $error("drive on after deselect");
  a_desel_quiet:
    assert property (stb && !sel ##1 nos [*2] |=> $stable(dq_out))
    else $error("data out moved while deselected");
  a_drive_dflt:
    assert property ($rose(aresetn) |-> drive_strength_sel)
    else $error("drive strength not at default");

  c_desel: cover property (stb && !sel ##1 nos [*2]);
  c_wr_pair: cover property (wr ##1 wr);
  c_oe_off: cover property (out_enable_n [*5]);
endmodule : sram_port_props

bind sync_burst_sram_port sram_port_props #(
  .LANES(LANES),
  .LANE_W(LANE_W)
) i_props (
  .aclk(aclk),
  .aresetn(aresetn),
  .proc_addr_strobe_n(proc_addr_strobe_n),
  .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
  .select_first_n(select_first_n),
  .select_second_hi(select_second_hi),
  .select_third_n(select_third_n),
  .all_bytes_write_n(all_bytes_write_n),
  .byte_write_qualifier_n(byte_write_qualifier_n),
  .out_enable_n(out_enable_n),
  .dq_out(dq_out),
  .dq_oe(dq_oe),
  .drive_strength_sel(drive_strength_sel)
);

`default_nettype wire

// [testbench/burst_host.sv]
// cache controller model driving the memory side of the port
`timescale 1ns/1ps
`default_nettype none

module burst_host (
  // clock
  input wire logic    aclk,
  // memory side
  output logic [18:0] ext_addr,
  output logic        proc_addr_strobe_n,
  output logic        ctrl_addr_strobe_n,
  output logic        burst_advance_n,
  output logic        select_first_n,
  output logic        select_second_hi,
  output logic        select_third_n,
  output logic        all_bytes_write_n,
  output logic        byte_write_qualifier_n,
  output logic [7:0]  lane_write_sel_n,
  output logic [71:0] dq_in
);
  initial begin
    {ext_addr, dq_in} = '0;
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = '1;
    {select_first_n, select_second_hi, select_third_n} = 3'b101;
    {all_bytes_write_n, byte_write_qualifier_n, lane_write_sel_n} = '1;
  end

  // s: advance, proc strobe, ctrl strobe; e: raw enables; w: qual, global
  task automatic cyc(input logic [2:0] s, e, input logic [1:0] w,
                     input logic [7:0] l, input logic [18:0] a,
                     input logic [71:0] d);
    @(posedge aclk);
    ctrl_addr_strobe_n <= !s[0];
    proc_addr_strobe_n <= !s[1];
    burst_advance_n <= !s[2];
    {select_first_n, select_second_hi, select_third_n} <= e;
    all_bytes_write_n <= !w[0];
    byte_write_qualifier_n <= !w[1];
    lane_write_sel_n <= l;
    ext_addr <= a;
    // released data lines toggle so stale values never match
    dq_in <= (|w) ? d : ~dq_in;
  endtask : cyc
endmodule : burst_host

`default_nettype wire

// [testbench/sync_burst_sram_port_tb.sv]
// self-checking bench for the burst sram port
`timescale 1ns/1ps
`default_nettype none

module sync_burst_sram_port_tb;
  typedef struct packed {
    logic [4:0] c;
    logic       p;
    logic [7:0] x;
  } row_s;
  // control value, proc strobe, four expected low address pairs
  row_s rows [4] = '{'{5'h15, 1'b0, 8'h6c}, '{5'h17, 1'b1, 8'h4e},
                     '{5'h14, 1'b0, 8'hb1}, '{5'h16, 1'b1, 8'he4}};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, out_enable_n = 1'b0;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [71:0] dq_out, dq_in;
  logic [7:0]  dq_oe, lane_write_sel_n;
  logic [18:0] ext_addr;
  logic        proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
  logic        select_first_n, select_second_hi, select_third_n;
  logic        all_bytes_write_n, byte_write_qualifier_n, drive_strength_sel;
  logic [71:0] s [7];
  int          fails = 0, check_count = 0, cycles = 0, k;

  always #10 aclk = ~aclk;

  sync_burst_sram_port i_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_addr(ext_addr), .proc_addr_strobe_n(proc_addr_strobe_n),
    .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
    .burst_advance_n(burst_advance_n), .select_first_n(select_first_n),
    .select_second_hi(select_second_hi), .select_third_n(select_third_n),
    .all_bytes_write_n(all_bytes_write_n),
    .byte_write_qualifier_n(byte_write_qualifier_n),
    .lane_write_sel_n(lane_write_sel_n), .out_enable_n(out_enable_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .drive_strength_sel(drive_strength_sel));

  burst_host i_host (.aclk(aclk), .ext_addr(ext_addr),
    .proc_addr_strobe_n(proc_addr_strobe_n),
    .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
    .burst_advance_n(burst_advance_n), .select_first_n(select_first_n),
    .select_second_hi(select_second_hi), .select_third_n(select_third_n),
    .all_bytes_write_n(all_bytes_write_n),
    .byte_write_qualifier_n(byte_write_qualifier_n),
    .lane_write_sel_n(lane_write_sel_n), .dq_in(dq_in));

  function automatic logic [71:0] pat(input logic [1:0] i);
    return {9{6'h2b, i}};
  endfunction : pat

  task automatic summarize;
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [71:0] g, e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic axw(input logic [31:0] a, d, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, r);
  endtask : axw

  task automatic axr(input logic [31:0] a, e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk({rresp, rdata}, {2'h0, e});
  endtask : axr

  // single read in flow-through mode, then a suspended cycle
  task automatic rd(input logic [18:0] a, input logic [71:0] e);
    i_host.cyc(3'b001, 3'b010, 2'b00, 8'hff, a, '0);
    i_host.cyc(3'b000, 3'b010, 2'b00, 8'hff, a, '0);
    #1 chk(dq_out, e);
  endtask : rd

  task automatic desel(input logic [2:0] c, input logic [7:0] e1, e2);
    i_host.cyc(3'b001, 3'b010, 2'b00, 8'hff, 19'h100, '0);
    i_host.cyc(3'b000, 3'b010, 2'b00, 8'hff, 19'h100, '0);
    i_host.cyc(3'b001, c, 2'b00, 8'hff, 19'h100, '0);
    i_host.cyc(3'b000, c, 2'b00, 8'hff, 19'h100, '0);
    #1 chk(dq_oe, e1);
    i_host.cyc(3'b000, c, 2'b00, 8'hff, 19'h100, '0);
    #1 chk(dq_oe, e2);
  endtask : desel

  always @(posedge aclk) begin
    cycles++;
    if (cycles > 3000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(drive_strength_sel, 1'b1);
    axr(32'h0, 32'h17);
    axw(32'h10, 32'h0, 2'h2);
    for (k = 0; k < 4; k++) begin
      i_host.cyc(3'b001, 3'b010, 2'b01, 8'hff, {17'h40, k[1:0]}, pat(k[1:0]));
    end
    foreach (rows[r]) begin
      axw(32'h0, {27'h0, rows[r].c}, 2'h0);
      i_host.cyc({1'b0, rows[r].p, !rows[r].p}, 3'b010, 2'b00, 8'hff,
                 {17'h40, rows[r].x[7:6]}, '0);
      for (k = 1; k < 7; k++) begin
        i_host.cyc({k < 5, 2'b00}, 3'b010, 2'b00, 8'hff, 19'h0, '0);
        #1 s[k] = dq_out;
      end
      for (k = 0; k < 5; k++) begin
        chk(s[k + 1 + rows[r].c[0]], pat(rows[r].x[7 - 2 * (k % 4) -: 2]));
      end
    end
    i_host.cyc(3'b001, 3'b010, 2'b10, 8'hfe, 19'h101, '0);
    i_host.cyc(3'b001, 3'b010, 2'b10, 8'hff, 19'h102, '0);
    i_host.cyc(3'b001, 3'b010, 2'b11, 8'hff, 19'h103, 72'h5);
    rd(19'h101, pat(2'd1) & ~72'h1ff);
    rd(19'h102, pat(2'd2));
    rd(19'h103, 72'h5);
    axw(32'h0, 32'h1e, 2'h0);
    i_host.cyc(3'b001, 3'b010, 2'b01, 8'hff, 19'h103, '0);
    i_host.cyc(3'b000, 3'b010, 2'b00, 8'hff, 19'h103, '0);
    axw(32'h0, 32'h16, 2'h0);
    rd(19'h103, 72'h5);
    for (k = 0; k < 8; k++) begin
      desel(k[2:0], k == 2 ? 8'hff : 8'h00, k == 2 ? 8'hff : 8'h00);
    end
    axw(32'h0, 32'h12, 2'h0);
    desel(3'b000, 8'hff, 8'h00);
    @(posedge aclk);
    out_enable_n <= 1'b1;
    repeat (6) i_host.cyc(3'b001, 3'b010, 2'b00, 8'hff, 19'h100, '0);
    #1 chk(dq_oe, 8'h00);
    summarize();
  end
endmodule : sync_burst_sram_port_tb

`default_nettype wire
